// ### cx_pkg.sv
// Package of opcodes, widths and shared types for the execute datapath
`default_nettype none
package cx_pkg;
	localparam int ACC_W = 8;
	localparam int REG_W = 12;
	localparam int PC_W = 12;
	localparam int SP_W = 3;
	localparam int NREG = 8;
	localparam int SCR_DEPTH = 64;
	localparam int SCR_AW = 6;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [11:0] REG_RST = 12'h000;
	localparam logic [11:0] PC_RST = 12'h000;
	localparam logic [11:0] PC_ONE = 12'h001;
	localparam logic [11:0] PC_TWO = 12'h002;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [11:0] ONE12 = 12'h001;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [3:0] BCD_SIX = 4'h6;
	// Status byte layout for readback
	localparam int ST_D_BIT = 7;
	localparam int ST_C_BIT = 6;
	localparam int ST_A_BIT = 5;
	localparam int ST_H_BIT = 4;
	localparam int ST_I_BIT = 3;
	typedef enum logic [4:0] {
		CX_OP_NOP = 5'b0_0000,
		CX_OP_ADD_SCRATCH = 5'b0_0001,
		CX_OP_AND = 5'b0_0010,
		CX_OP_ACC_TO_PAGE = 5'b0_0011,
		CX_OP_ACC_TO_REG = 5'b0_0100,
		CX_OP_ZERO_ACC = 5'b0_0101,
		CX_OP_ZERO_ACC_C = 5'b0_0110,
		CX_OP_ZERO_C = 5'b0_0111,
		CX_OP_INV_ACC = 5'b0_1000,
		CX_OP_INV_C = 5'b0_1001,
		CX_OP_COMPARE = 5'b0_1010,
		CX_OP_PAGE_TO_ACC = 5'b0_1011,
		CX_OP_REG_TO_ACC = 5'b0_1100,
		CX_OP_STATUS_TO_ACC = 5'b0_1101,
		CX_OP_DEC_ACC = 5'b0_1110,
		CX_OP_DEC_REG = 5'b0_1111,
		CX_OP_SKIP = 5'b1_0000,
		CX_OP_DEC_BRANCH = 5'b1_0001,
		CX_OP_INT_OFF = 5'b1_0010,
		CX_OP_INT_ON = 5'b1_0011,
		CX_OP_INC_ACC = 5'b1_0100,
		CX_OP_BUS_READ = 5'b1_0101,
		CX_OP_ADD_REG = 5'b1_0110,
		CX_OP_SEL_DEC = 5'b1_0111,
		CX_OP_SEL_BIN = 5'b1_1000
	} cx_op_t;
	typedef struct packed {
		logic valid;
		cx_op_t op;
		logic [7:0] opcode;
		logic [7:0] operand;
		logic [11:0] pc;
		logic [2:0] sp;
	} cx_instr_t;
	typedef struct packed {
		logic dec;
		logic carry;
		logic nonzero;
		logic half;
		logic int_en;
	} cx_flags_t;
endpackage : cx_pkg
`default_nettype wire

// ### cx_execute.sv
// Execute datapath for one run of the 8-bit instruction set
`default_nettype none
module cx_execute #(
	parameter int SCR_DEPTH = cx_pkg::SCR_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cx_pkg::cx_instr_t instr,
	input wire logic irq_req,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid,
	output var logic [7:0] acc,
	output var cx_pkg::cx_flags_t flags,
	output var logic [11:0] next_pc,
	output var logic done,
	output var logic [11:0] bus_addr,
	output var logic bus_rd,
	output var logic irq_ack,
	output var logic [95:0] regs_flat
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sum;
		logic c;
		logic h;
	} cx_alu_t;

	function automatic cx_alu_t cx_add(input logic [7:0] a,
		input logic [7:0] b, input logic cin, input logic dec);
		logic [4:0] lo;
		logic [4:0] hi;
		logic hc;
		cx_alu_t r;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'b0000, cin};
		hc = lo[4];
		if (dec && (lo > {1'b0, cx_pkg::BCD_NINE})) begin
			lo = lo + {1'b0, cx_pkg::BCD_SIX};
			hc = 1'b1;
		end
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'b0000, hc};
		r.c = hi[4];
		if (dec && (hi > {1'b0, cx_pkg::BCD_NINE})) begin
			hi = hi + {1'b0, cx_pkg::BCD_SIX};
			r.c = 1'b1;
		end
		r.sum = {hi[3:0], lo[3:0]};
		r.h = hc;
		return r;
	endfunction : cx_add

	function automatic cx_alu_t cx_dec(input logic [7:0] a,
		input logic dec);
		cx_alu_t r;
		r.sum = a - cx_pkg::ONE8;
		r.c = (a == 8'h00);
		r.h = 1'b0;
		if (dec) begin
			if (a[3:0] == 4'h0) begin
				r.h = 1'b1;
				r.sum[3:0] = cx_pkg::BCD_NINE;
				r.sum[7:4] = (a[7:4] == 4'h0) ? cx_pkg::BCD_NINE :
					a[7:4] - 4'h1;
			end else begin
				r.sum = {a[7:4], a[3:0] - 4'h1};
			end
		end
		return r;
	endfunction : cx_dec

	// Branch target lands in page of the byte after the operand
	function automatic logic [11:0] cx_target(input logic [11:0] pc,
		input logic [7:0] low);
		logic [11:0] nxt;
		nxt = pc + cx_pkg::PC_TWO;
		return {nxt[11:8], low};
	endfunction : cx_target

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] scratch [SCR_DEPTH];
	logic [11:0] regs_q [cx_pkg::NREG];
	logic [11:0] regs_d [cx_pkg::NREG];
	logic [7:0] acc_q, acc_d;
	cx_pkg::cx_flags_t flg_q, flg_d;
	logic [11:0] pc_q, pc_d;
	logic done_q, done_d;
	logic [11:0] addr_q, addr_d;
	logic rd_q, rd_d;
	logic ack_q, ack_d;
	logic cmp_lock_q, cmp_lock_d;
	logic en_pend_q, en_pend_d;
	logic wait_q, wait_d;
	logic [2:0] sel;
	logic [11:0] rsel;
	logic [11:0] rdec;
	cx_alu_t alu;
	logic retire;

	assign sel = instr.opcode[2:0];
	assign rsel = regs_q[sel];
	assign rdec = rsel - cx_pkg::ONE12;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < cx_pkg::NREG; i++) begin
			regs_d[i] = regs_q[i];
		end
		acc_d = acc_q;
		flg_d = flg_q;
		pc_d = pc_q;
		done_d = 1'b0;
		addr_d = addr_q;
		rd_d = 1'b0;
		ack_d = 1'b0;
		cmp_lock_d = cmp_lock_q;
		en_pend_d = en_pend_q;
		wait_d = wait_q;
		alu = '0;
		retire = 1'b0;
		if (wait_q) begin
			rd_d = 1'b1;
			if (bus_rvalid) begin
				acc_d = bus_rdata;
				rd_d = 1'b0;
				wait_d = 1'b0;
				done_d = 1'b1;
				retire = 1'b1;
			end
		end else if (instr.valid) begin
			pc_d = instr.pc + cx_pkg::PC_ONE;
			done_d = 1'b1;
			retire = 1'b1;
			case (instr.op)
				cx_pkg::CX_OP_ADD_SCRATCH: begin
					alu = cx_add(acc_q, scratch[rsel[5:0]], flg_q.carry,
						flg_q.dec);
					acc_d = alu.sum;
					flg_d.carry = alu.c;
					flg_d.half = alu.h;
					flg_d.nonzero = (alu.sum != 8'h00);
				end
				cx_pkg::CX_OP_ADD_REG: begin
					alu = cx_add(acc_q, rsel[7:0], flg_q.carry,
						flg_q.dec);
					acc_d = alu.sum;
					flg_d.carry = alu.c;
					flg_d.half = alu.h;
					flg_d.nonzero = (alu.sum != 8'h00);
				end
				cx_pkg::CX_OP_AND: begin
					acc_d = acc_q & rsel[7:0];
					flg_d.carry = 1'b0;
					flg_d.half = 1'b0;
					flg_d.nonzero = ((acc_q & rsel[7:0]) != 8'h00);
				end
				cx_pkg::CX_OP_ACC_TO_PAGE: begin
					regs_d[sel] = {acc_q[3:0], rsel[7:0]};
				end
				cx_pkg::CX_OP_ACC_TO_REG: begin
					regs_d[sel] = {rsel[11:8], acc_q};
				end
				cx_pkg::CX_OP_ZERO_ACC: begin
					acc_d = cx_pkg::ACC_RST;
				end
				cx_pkg::CX_OP_ZERO_ACC_C: begin
					acc_d = cx_pkg::ACC_RST;
					flg_d.carry = 1'b0;
				end
				cx_pkg::CX_OP_ZERO_C: begin
					flg_d.carry = 1'b0;
				end
				cx_pkg::CX_OP_INV_C: begin
					flg_d.carry = ~flg_q.carry;
				end
				cx_pkg::CX_OP_INV_ACC: begin
					acc_d = ~acc_q;
					flg_d.nonzero = (acc_q != 8'hFF);
				end
				cx_pkg::CX_OP_COMPARE: begin
					flg_d.carry = (acc_q < rsel[7:0]);
					flg_d.nonzero = (acc_q != rsel[7:0]);
				end
				cx_pkg::CX_OP_PAGE_TO_ACC: begin
					// Only R0-R3 hold a page that can be read back
					if (sel[2] == 1'b0) begin
						acc_d = {4'h0, rsel[11:8]};
					end
				end
				cx_pkg::CX_OP_REG_TO_ACC: begin
					acc_d = rsel[7:0];
				end
				cx_pkg::CX_OP_STATUS_TO_ACC: begin
					acc_d = 8'h00;
					acc_d[cx_pkg::ST_D_BIT] = flg_q.dec;
					acc_d[cx_pkg::ST_C_BIT] = flg_q.carry;
					acc_d[cx_pkg::ST_A_BIT] = flg_q.nonzero;
					acc_d[cx_pkg::ST_H_BIT] = flg_q.half;
					acc_d[cx_pkg::ST_I_BIT] = flg_q.int_en;
					acc_d[2:0] = instr.sp;
				end
				cx_pkg::CX_OP_DEC_ACC: begin
					alu = cx_dec(acc_q, flg_q.dec);
					acc_d = alu.sum;
					flg_d.carry = alu.c;
					if (flg_q.dec) begin
						flg_d.half = alu.h;
					end
					flg_d.nonzero = (alu.sum != 8'h00);
				end
				cx_pkg::CX_OP_INC_ACC: begin
					alu = cx_add(acc_q, cx_pkg::ONE8, 1'b0,
						flg_q.dec);
					acc_d = alu.sum;
					flg_d.carry = alu.c;
					if (flg_q.dec) begin
						flg_d.half = alu.h;
					end
					flg_d.nonzero = (alu.sum != 8'h00);
				end
				cx_pkg::CX_OP_DEC_REG: begin
					regs_d[sel] = rdec;
				end
				cx_pkg::CX_OP_SKIP: begin
					pc_d = instr.pc + cx_pkg::PC_TWO;
				end
				cx_pkg::CX_OP_DEC_BRANCH: begin
					regs_d[sel] = rdec;
					pc_d = instr.pc + cx_pkg::PC_TWO;
					if (rdec[7:0] != 8'h00) begin
						pc_d = cx_target(instr.pc, instr.operand);
					end
				end
				cx_pkg::CX_OP_INT_OFF: begin
					flg_d.int_en = 1'b0;
					en_pend_d = 1'b0;
				end
				cx_pkg::CX_OP_INT_ON: begin
					en_pend_d = 1'b1;
				end
				cx_pkg::CX_OP_SEL_DEC: begin
					flg_d.dec = 1'b1;
				end
				cx_pkg::CX_OP_SEL_BIN: begin
					flg_d.dec = 1'b0;
				end
				cx_pkg::CX_OP_BUS_READ: begin
					addr_d = rsel;
					rd_d = 1'b1;
					wait_d = 1'b1;
					done_d = 1'b0;
					retire = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// Acknowledge is sampled only at an instruction boundary
		if (retire) begin
			// Pending enable becomes live once the next one retires
			if (en_pend_q && (wait_q || instr.op != cx_pkg::CX_OP_INT_ON)) begin
				flg_d.int_en = 1'b1;
				en_pend_d = 1'b0;
			end
			if (instr.op == cx_pkg::CX_OP_COMPARE && !wait_q) begin
				cmp_lock_d = 1'b1;
			end else begin
				cmp_lock_d = 1'b0;
				if (irq_req && flg_q.int_en && !cmp_lock_q) begin
					ack_d = 1'b1;
					// Acknowledge wins over an enable still pending
					flg_d.int_en = 1'b0;
					en_pend_d = 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < cx_pkg::NREG; i++) begin
				regs_q[i] <= cx_pkg::REG_RST;
			end
			acc_q <= cx_pkg::ACC_RST;
			flg_q <= '0;
			pc_q <= cx_pkg::PC_RST;
			done_q <= 1'b0;
			addr_q <= cx_pkg::REG_RST;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			cmp_lock_q <= 1'b0;
			en_pend_q <= 1'b0;
			wait_q <= 1'b0;
			// No write path here; cleared so a scratch add reads a known byte
			for (int i = 0; i < SCR_DEPTH; i++) begin
				scratch[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < cx_pkg::NREG; i++) begin
				regs_q[i] <= regs_d[i];
			end
			acc_q <= acc_d;
			flg_q <= flg_d;
			pc_q <= pc_d;
			done_q <= done_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			ack_q <= ack_d;
			cmp_lock_q <= cmp_lock_d;
			en_pend_q <= en_pend_d;
			wait_q <= wait_d;
		end
	end

	always_comb begin
		for (int i = 0; i < cx_pkg::NREG; i++) begin
			regs_flat[i*12 +: 12] = regs_q[i];
		end
	end

	assign acc = acc_q;
	assign flags = flg_q;
	assign next_pc = pc_q;
	assign done = done_q;
	assign bus_addr = addr_q;
	assign bus_rd = rd_q;
	assign irq_ack = ack_q;
endmodule : cx_execute
`default_nettype wire

// ### cx_bus_model.sv
// Memory and I/O responder on the execute block's read bus
`default_nettype none
module cx_bus_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [7:0] ans,
	input wire logic [3:0] lat,
	output var logic [7:0] bus_rdata,
	output var logic bus_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	logic served_q;
	// Idle bus toggles so a stale byte is never mistaken for data
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_q <= 4'h0;
			served_q <= 1'b0;
			bus_rvalid <= 1'b0;
			bus_rdata <= 8'h00;
		end else if (bus_rd && !served_q && wait_q == lat) begin
			bus_rdata <= ans ^ bus_addr[7:0];
			bus_rvalid <= 1'b1;
			served_q <= 1'b1;
		end else begin
			bus_rdata <= ~bus_rdata;
			bus_rvalid <= 1'b0;
			served_q <= bus_rd && served_q;
			wait_q <= bus_rd ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule : cx_bus_model
`default_nettype wire

// ### cx_execute_asserts.sv
// Port-level assertions for the execute datapath
`default_nettype none
module cx_execute_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cx_pkg::cx_instr_t instr,
	input wire logic irq_req,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire logic [7:0] acc,
	input wire cx_pkg::cx_flags_t flags,
	input wire logic [11:0] next_pc,
	input wire logic done,
	input wire logic [11:0] bus_addr,
	input wire logic bus_rd,
	input wire logic irq_ack,
	input wire logic [95:0] regs_flat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic [11:0] sel_reg;
	assign take = instr.valid && !bus_rd;
	assign sel_reg = regs_flat[12*instr.opcode[2:0] +: 12];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_zero_acc: assert property (take && instr.op == cx_pkg::CX_OP_ZERO_ACC
		|=> done && acc == 8'h00) else $error("acc not cleared");
	a_carry_clear: assert property (take && instr.op == cx_pkg::CX_OP_ZERO_C
		|=> !flags.carry && $stable(acc)) else $error("carry clear bad");
	a_carry_flip: assert property (take && instr.op == cx_pkg::CX_OP_INV_C
		|=> flags.carry != $past(flags.carry)) else $error("carry not inverted");
	a_acc_invert: assert property (take && instr.op == cx_pkg::CX_OP_INV_ACC
		|=> acc == ~$past(acc) && flags.nonzero == (acc != 8'h00))
		else $error("invert bad");
	a_skip_two: assert property (take && instr.op == cx_pkg::CX_OP_SKIP
		|=> next_pc == $past(instr.pc) + 12'h002) else $error("skip pc bad");
	a_cmp_lock: assert property (take && instr.op == cx_pkg::CX_OP_COMPARE
		|=> !irq_ack && $stable(acc)) else $error("ack during compare");
	a_read_addr: assert property (take && instr.op == cx_pkg::CX_OP_BUS_READ
		|=> bus_rd && bus_addr == $past(sel_reg)) else $error("read address bad");
	a_read_data: assert property (bus_rd && bus_rvalid
		|=> done && !bus_rd && acc == $past(bus_rdata)) else $error("read data bad");
	c_read: cover property (bus_rd && bus_rvalid);
	c_compare: cover property (take && instr.op == cx_pkg::CX_OP_COMPARE);
	c_ack: cover property (irq_ack);
endmodule : cx_execute_asserts
bind cx_execute cx_execute_asserts chk (.clk(clk), .sys_rst(sys_rst),
	.instr(instr), .irq_req(irq_req), .bus_rdata(bus_rdata),
	.bus_rvalid(bus_rvalid), .acc(acc), .flags(flags), .next_pc(next_pc),
	.done(done), .bus_addr(bus_addr), .bus_rd(bus_rd), .irq_ack(irq_ack),
	.regs_flat(regs_flat));
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the execute datapath
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic irq_req = 1'b0;
	cx_pkg::cx_instr_t instr = '0;
	cx_pkg::cx_flags_t flags;
	logic [7:0] bus_rdata, acc;
	logic [7:0] ans = 8'h00;
	logic [3:0] lat = 4'h2;
	logic [11:0] next_pc, bus_addr;
	logic bus_rvalid, done, bus_rd, irq_ack;
	logic [95:0] regs_flat;
	int n_fail = 0;
	int checks_done = 0;
	int acks = 0;
	always #2.5 clk = ~clk;
	always @(negedge clk) if (irq_ack === 1'b1) acks++;
	cx_execute dut (.clk(clk), .sys_rst(sys_rst), .instr(instr),
		.irq_req(irq_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.acc(acc), .flags(flags), .next_pc(next_pc), .done(done),
		.bus_addr(bus_addr), .bus_rd(bus_rd), .irq_ack(irq_ack),
		.regs_flat(regs_flat));
	cx_bus_model partner (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .ans(ans), .lat(lat), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid));
	function automatic logic [11:0] r(input int i);
		return regs_flat[12*i +: 12];
	endfunction : r
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	// -------------------------
	// One instruction, waits for retire
	// -------------------------
	task automatic run(input cx_pkg::cx_op_t op, input logic [7:0] opc);
		int i;
		@(negedge clk);
		instr.valid = 1'b1;
		instr.op = op;
		instr.opcode = opc;
		@(negedge clk);
		instr.valid = 1'b0;
		for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
		if (done !== 1'b1) begin
			n_fail++;
			stop_test();
		end
	endtask : run
	// R1 stays zero, so the responder returns ans unchanged
	task automatic load(input logic [7:0] v);
		ans = v;
		run(cx_pkg::CX_OP_BUS_READ, 8'h01);
		`CHK(acc, v)
	endtask : load
	task automatic t_moves;
		load(8'h5A);
		run(cx_pkg::CX_OP_ACC_TO_REG, 8'h02);
		`CHK(r(2), 12'h05A)
		run(cx_pkg::CX_OP_ACC_TO_PAGE, 8'h02);
		`CHK({r(2), acc}, 20'hA_5A5A)
		lat = 4'h0;
		ans = 8'h0F;
		run(cx_pkg::CX_OP_BUS_READ, 8'h02);
		`CHK(acc, 8'h55)
		run(cx_pkg::CX_OP_PAGE_TO_ACC, 8'h02);
		`CHK(acc, 8'h0A)
		run(cx_pkg::CX_OP_PAGE_TO_ACC, 8'h06);
		`CHK(acc, 8'h0A)
		run(cx_pkg::CX_OP_REG_TO_ACC, 8'h02);
		`CHK(acc, 8'h5A)
		run(cx_pkg::CX_OP_DEC_REG, 8'h00);
		`CHK(r(0), 12'hFFF)
		load(8'h00);
		run(cx_pkg::CX_OP_ACC_TO_REG, 8'h02);
		run(cx_pkg::CX_OP_DEC_REG, 8'h02);
		`CHK(r(2), 12'h9FF)
		$display("moves finished");
	endtask : t_moves
	task automatic t_logic;
		load(8'h5A);
		run(cx_pkg::CX_OP_INV_ACC, 8'h00);
		`CHK({acc, flags.nonzero}, 9'h14B)
		load(8'hF3);
		run(cx_pkg::CX_OP_ACC_TO_REG, 8'h03);
		load(8'h3E);
		run(cx_pkg::CX_OP_ZERO_C, 8'h00);
		`CHK(flags.carry, 1'b0)
		run(cx_pkg::CX_OP_INV_C, 8'h00);
		`CHK({flags.carry, acc}, 9'h13E)
		run(cx_pkg::CX_OP_AND, 8'h03);
		`CHK({flags.carry, flags.half, flags.nonzero, acc}, 11'h132)
		run(cx_pkg::CX_OP_INV_C, 8'h00);
		run(cx_pkg::CX_OP_ZERO_ACC_C, 8'h00);
		`CHK({flags.carry, acc}, 9'h000)
		run(cx_pkg::CX_OP_INV_C, 8'h00);
		run(cx_pkg::CX_OP_ZERO_ACC, 8'h00);
		`CHK({flags.carry, acc}, 9'h100)
		$display("logic finished");
	endtask : t_logic
	// Odd rows decimal, rows 4..7 increment
	task automatic t_arith;
		logic [7:0] st [8] = '{8'h80, 8'h80, 8'h00, 8'h00,
			8'h79, 8'h79, 8'h99, 8'h99};
		logic [7:0] ex [8] = '{8'h7F, 8'h79, 8'hFF, 8'h99,
			8'h7A, 8'h80, 8'h9A, 8'h00};
		logic [7:0] cy = 8'h8C;
		for (int i = 0; i < 8; i++) begin
			load(st[i]);
			if (i % 2) run(cx_pkg::CX_OP_SEL_DEC, 8'h00);
			else run(cx_pkg::CX_OP_SEL_BIN, 8'h00);
			if (i < 4) run(cx_pkg::CX_OP_DEC_ACC, 8'h00);
			else run(cx_pkg::CX_OP_INC_ACC, 8'h00);
			`CHK({acc, flags.carry}, {ex[i], cy[i]})
			`CHK(flags.nonzero, ex[i] != 8'h00)
			if (i % 2) `CHK(flags.half, 1'b1)
		end
		instr.sp = 3'h5;
		run(cx_pkg::CX_OP_STATUS_TO_ACC, 8'h00);
		`CHK(acc, 8'hD5)
		run(cx_pkg::CX_OP_SEL_BIN, 8'h00);
		run(cx_pkg::CX_OP_ADD_REG, 8'h03);
		`CHK({flags.carry, flags.nonzero, acc}, 10'h3C9)
		run(cx_pkg::CX_OP_ADD_SCRATCH, 8'h03);
		`CHK({flags.carry, flags.nonzero, acc}, 10'h1CA)
		$display("arithmetic finished");
	endtask : t_arith
	task automatic t_compare;
		logic [7:0] cv [3] = '{8'hF3, 8'h30, 8'hF8};
		logic [1:0] cf [3] = '{2'h0, 2'h3, 2'h1};
		for (int i = 0; i < 3; i++) begin
			load(cv[i]);
			run(cx_pkg::CX_OP_COMPARE, 8'h03);
			`CHK({flags.carry, flags.nonzero, acc}, {cf[i], cv[i]})
		end
		$display("compare finished");
	endtask : t_compare
	task automatic t_flow;
		instr.pc = 12'h3FE;
		run(cx_pkg::CX_OP_SKIP, 8'h00);
		`CHK(next_pc, 12'h400)
		instr.pc = 12'h3FF;
		instr.operand = 8'h4A;
		run(cx_pkg::CX_OP_DEC_BRANCH, 8'h04);
		`CHK({r(4), next_pc}, 24'hFF_F44A)
		load(8'h01);
		run(cx_pkg::CX_OP_ACC_TO_REG, 8'h04);
		instr.pc = 12'h120;
		run(cx_pkg::CX_OP_DEC_BRANCH, 8'h04);
		`CHK({r(4), next_pc}, 24'hF0_0122)
		$display("flow finished");
	endtask : t_flow
	task automatic t_irq;
		irq_req = 1'b1;
		run(cx_pkg::CX_OP_INT_OFF, 8'h00);
		`CHK(flags.int_en, 1'b0)
		run(cx_pkg::CX_OP_NOP, 8'h00);
		run(cx_pkg::CX_OP_INT_ON, 8'h00);
		`CHK({irq_ack, flags.int_en}, 2'b00)
		run(cx_pkg::CX_OP_NOP, 8'h00);
		`CHK({irq_ack, flags.int_en}, 2'b01)
		run(cx_pkg::CX_OP_COMPARE, 8'h03);
		`CHK({irq_ack, flags.int_en}, 2'b01)
		run(cx_pkg::CX_OP_NOP, 8'h00);
		`CHK({irq_ack, flags.int_en}, 2'b01)
		run(cx_pkg::CX_OP_NOP, 8'h00);
		`CHK({irq_ack, flags.int_en}, 2'b10)
		@(negedge clk);
		`CHK(acks, 1)
		irq_req = 1'b0;
		$display("interrupts finished");
	endtask : t_irq
	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		`CHK({acc, flags, next_pc}, 25'h000_0000)
		t_moves();
		t_logic();
		t_arith();
		t_compare();
		t_flow();
		t_irq();
		stop_test();
	end
endmodule : tb
`default_nettype wire
